// [rtl/bigram_pkg.sv]
// shared constants and carriers for the large dual-port ram block
// assumes one clock domain; user logic drives all port fields
package bigram_pkg;

  // array geometry: 4k rows of sixteen 9-bit lanes
  localparam int LANE_W     = 9;
  localparam int LANES      = 16;
  localparam int ROWS       = 4096;
  localparam int ROW_W      = LANE_W * LANES;
  localparam int TOTAL_BITS = 589824;
  localparam int ROW_AW     = 12;

  // per-port pin widths
  localparam int ADDR_W  = 16;
  localparam int PORT_W  = 72;
  localparam int PORT_BE = 8;

  // reset values
  localparam logic [PORT_W-1:0]  DOUT_RST = 72'h0;
  localparam logic [PORT_BE-1:0] BE_ALL   = 8'hff;

  // operating modes
  typedef enum logic [1:0] {
    MODE_TDP  = 2'b00,
    MODE_SDP  = 2'b01,
    MODE_SP   = 2'b11,
    MODE_FIFO = 2'b10
  } mode_t;

  // port organisation: lanes per word is 1 << code
  typedef enum logic [2:0] {
    W9   = 3'h0,
    W18  = 3'h1,
    W36  = 3'h2,
    W72  = 3'h3,
    W144 = 3'h4
  } width_t;

  // one port's request inputs
  typedef struct packed {
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [PORT_W-1:0]   din;
    logic [PORT_BE-1:0]  be;
  } req_t;

  // static configuration chosen by the user
  typedef struct packed {
    mode_t   mode;
    width_t  wc_a;
    width_t  wc_b;
    logic    outreg_a;
    logic    outreg_b;
  } cfg_t;

endpackage

// [rtl/bigram.sv]
// large embedded synchronous ram with two configurable ports
// assumes inputs synchronous to core_clk; one clock serves both ports
`timescale 1ns/100ps

module bigram
  import bigram_pkg::*;
(
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // configuration
  input  wire bigram_pkg::cfg_t        cfg,
  // port a controls and data
  input  wire logic                    ce_a,
  input  wire logic                    clr_a,
  input  wire bigram_pkg::req_t        req_a,
  // port b controls and data
  input  wire logic                    ce_b,
  input  wire logic                    clr_b,
  input  wire bigram_pkg::req_t        req_b,
  // read data and status
  output logic [bigram_pkg::PORT_W-1:0] dout_a,
  output logic [bigram_pkg::PORT_W-1:0] dout_b,
  output logic                         cfg_err
);
  import bigram_pkg::*;

  // storage, no reset and no preload
  logic [ROW_W-1:0] mem [ROWS];

  // registered inputs and pending writes
  req_t             ra_r;
  req_t             rb_r;
  logic             pend_a_r;
  logic             pend_b_r;
  logic             err_r;
  logic [ROW_W-1:0] pipe_a_r;
  logic [ROW_W-1:0] pipe_b_r;
  logic [PORT_W-1:0] dout_a_r;
  logic [PORT_W-1:0] dout_b_r;

  // decoded mode flags
  logic is_tdp;
  logic is_two;
  logic wide;
  logic en_a;
  logic en_b;
  logic wr_a;
  logic wr_b;
  logic a_from_b;

  // lane addressing
  logic [ADDR_W-1:0] lidx_a;
  logic [ADDR_W-1:0] lidx_b;
  logic [ROW_AW-1:0] row_a;
  logic [ROW_AW-1:0] row_b;
  logic [3:0]        l0_a;
  logic [3:0]        l0_b;
  logic [4:0]        nl_a;
  logic [4:0]        nl_b;
  logic [ROW_W-1:0]  wdin_a;
  logic [LANES-1:0]  wbe_a;
  logic [ROW_W-1:0]  rd_a;
  logic [ROW_W-1:0]  rd_b;
  logic [LANE_W-1:0] lane0_old;

  // mode decode; b is idle in single-port mode
  assign is_tdp = (cfg.mode == MODE_TDP);
  assign is_two = (cfg.mode != MODE_SP);
  assign wide   = (cfg.wc_a == W144);
  assign en_a   = clk_en & ce_a;
  assign en_b   = clk_en & ce_b & is_two;
  // in 144 mode port a's pins carry the low half of the read
  assign a_from_b = wide & ~is_tdp;

  // write strobes from registered inputs; error blocks writes
  assign wr_a = clk_en & pend_a_r & ~err_r;
  assign wr_b = clk_en & pend_b_r & ~err_r & is_tdp;

  // word to lane mapping: word spans 1 << code lanes
  assign lidx_a = ADDR_W'(ra_r.addr << cfg.wc_a);
  assign lidx_b = ADDR_W'(rb_r.addr << cfg.wc_b);
  assign row_a  = lidx_a[ADDR_W-1:4];
  assign row_b  = lidx_b[ADDR_W-1:4];
  assign l0_a   = lidx_a[3:0];
  assign l0_b   = lidx_b[3:0];
  assign nl_a   = 5'(1 << cfg.wc_a);
  assign nl_b   = 5'(1 << cfg.wc_b);

  // 144-wide writes join both ports' data and masks
  assign wdin_a = wide ? {rb_r.din, ra_r.din}
                       : {{PORT_W{1'b0}}, ra_r.din};
  assign wbe_a  = wide ? {rb_r.be, ra_r.be}
                       : {{PORT_BE{1'b0}}, ra_r.be};

  // old value of the first lane a write aims at
  assign lane0_old = mem[row_a][int'(l0_a)*LANE_W +: LANE_W];

  // configuration check, registered
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      err_r <= 1'b0;
    else if (clk_en)
    begin
      unique case (cfg.mode)
        MODE_TDP:
          err_r <= (cfg.wc_a > W72) | (cfg.wc_b > W72);
        MODE_SP:
          err_r <= (cfg.wc_a > W72);
        default:
          err_r <= (cfg.wc_a > W144) | (cfg.wc_b > W144)
                 | ((cfg.wc_a == W144) != (cfg.wc_b == W144));
      endcase
    end
  end

  // port a input registers, one clock for all
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ra_r     <= '0;
      pend_a_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ce_a)
        ra_r <= req_a;
      pend_a_r <= ce_a & req_a.we;
    end
  end

  // port b input registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rb_r     <= '0;
      pend_b_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ce_b & is_two)
        rb_r <= req_b;
      pend_b_r <= ce_b & is_two & req_b.we;
    end
  end

  // array writes; b's pass runs after all of a's, so b wins a shared lane
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_a && (i < int'(nl_a)) && wbe_a[i])
        mem[row_a][(int'(l0_a) + i)*LANE_W +: LANE_W]
          <= wdin_a[i*LANE_W +: LANE_W];
    end
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_b && (i < int'(nl_b)) && (i < PORT_BE) && rb_r.be[i])
        mem[row_b][(int'(l0_b) + i)*LANE_W +: LANE_W]
          <= rb_r.din[i*LANE_W +: LANE_W];
    end
  end

  // array reads at the registered address, old data on collision
  always_comb
  begin
    rd_a = '0;
    rd_b = '0;
    for (int i = 0; i < LANES; i++)
    begin
      if (i < int'(nl_a))
        rd_a[i*LANE_W +: LANE_W] =
          mem[row_a][(int'(l0_a) + i)*LANE_W +: LANE_W];
      if (i < int'(nl_b))
        rd_b[i*LANE_W +: LANE_W] =
          mem[row_b][(int'(l0_b) + i)*LANE_W +: LANE_W];
    end
  end

  // optional output stage, port a (fed by b in 144 mode)
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pipe_a_r <= '0;
      dout_a_r <= DOUT_RST;
    end
    else if (clk_en && (a_from_b ? clr_b : clr_a))
    begin
      pipe_a_r <= '0;
      dout_a_r <= DOUT_RST;
    end
    else if (a_from_b ? en_b : en_a)
    begin
      pipe_a_r <= a_from_b ? rd_b : rd_a;
      if (a_from_b ? cfg.outreg_b : cfg.outreg_a)
        dout_a_r <= pipe_a_r[PORT_W-1:0];
      else if (a_from_b)
        dout_a_r <= rd_b[PORT_W-1:0];
      else
        dout_a_r <= rd_a[PORT_W-1:0];
    end
  end

  // optional output stage, port b (high half in 144 mode)
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pipe_b_r <= '0;
      dout_b_r <= DOUT_RST;
    end
    else if (clk_en && clr_b)
    begin
      pipe_b_r <= '0;
      dout_b_r <= DOUT_RST;
    end
    else if (en_b)
    begin
      pipe_b_r <= rd_b;
      if (cfg.outreg_b)
        dout_b_r <= wide ? pipe_b_r[ROW_W-1:PORT_W]
                         : pipe_b_r[PORT_W-1:0];
      else
        dout_b_r <= wide ? rd_b[ROW_W-1:PORT_W]
                         : rd_b[PORT_W-1:0];
    end
  end

  // outputs straight from flops
  assign dout_a  = dout_a_r;
  assign dout_b  = dout_b_r;
  assign cfg_err = err_r;

  // 144-bit width flagged in true dual-port
  property p_tdp_wide;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && is_tdp && (cfg.wc_a == W144) |=> cfg_err;
  endproperty
  a_tdp_wide: assert property (p_tdp_wide)
    else $error("144 width accepted in true dual-port");

  // 144 paired with a narrower width flagged
  property p_mix_wide;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && (cfg.mode == MODE_SDP) && (cfg.wc_a == W144)
      && (cfg.wc_b != W144) |=> cfg_err;
  endproperty
  a_mix_wide: assert property (p_mix_wide)
    else $error("144 width paired with a narrower one");

  // captured request equals the pins one edge before
  property p_capture;
    @(posedge core_clk) disable iff (!rst_n)
    en_a |=> (ra_r == $past(req_a));
  endproperty
  a_capture: assert property (p_capture)
    else $error("port a input not captured");

  // enable low freezes the input register across the next edge
  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !ce_a ##1 !ce_a |-> $stable(ra_r) && !pend_a_r;
  endproperty
  a_hold: assert property (p_hold)
    else $error("port a input moved with enable low");

  // no write without the write enable
  property p_no_we;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !req_a.we |=> !pend_a_r ##1 1'b1;
  endproperty
  a_no_we: assert property (p_no_we)
    else $error("write pending without write enable");

  // port b never writes outside true dual-port
  property p_b_rdonly;
    @(posedge core_clk) disable iff (!rst_n)
    !is_tdp |-> !wr_b;
  endproperty
  a_b_rdonly: assert property (p_b_rdonly)
    else $error("port b wrote outside true dual-port");

  // masked lane keeps its value
  property p_mask_keep;
    @(posedge core_clk) disable iff (!rst_n)
    wr_a && !wbe_a[0] && !wr_b |=>
      mem[$past(row_a)][int'($past(l0_a))*LANE_W +: LANE_W]
        == $past(lane0_old);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("masked lane changed");

  // enabled lane takes the write data
  property p_mask_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr_a && wbe_a[0] && !wr_b |=>
      mem[$past(row_a)][int'($past(l0_a))*LANE_W +: LANE_W]
        == $past(wdin_a[LANE_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("enabled lane not written");

  // clear empties the output two edges running
  property p_clear;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && clr_b ##1 clk_en && clr_b |-> dout_b == DOUT_RST;
  endproperty
  a_clear: assert property (p_clear)
    else $error("port b output not cleared");

endmodule // bigram

// [dv/bigram_user.sv]
// fabric-side user logic model that drives one port of the ram block
// assumes the bench loads commands just after a rising edge
`timescale 1ns/100ps
module bigram_user
  import bigram_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // command from the bench
  input  wire logic             go,
  input  wire logic             en,
  input  wire bigram_pkg::req_t cmd,
  // port side
  output logic                  ce,
  output bigram_pkg::req_t      req
);
  import bigram_pkg::*;

  // fields move only at an edge; idle fields toggle so stale data
  // never passes for a live request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ce  <= 1'b0;
      req <= '0;
    end
    else
    begin
      ce <= en;
      if (go)
        req <= cmd;
      else
        req <= ~req;
    end
  end
endmodule // bigram_user

// [dv/bigram_tb.sv]
// self-checking bench for the large dual-port ram block
// assumes one core clock; two fabric models drive ports a and b
`timescale 1ns/100ps
module bigram_tb;
  import bigram_pkg::*;

  typedef struct packed {
    mode_t       m;
    width_t      w;
    logic        o;
    logic [15:0] a;
    logic [8:0]  p;
    logic [15:0] b;
  } row_t;

  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         clk_en = 1'b1;
  logic         clr_a = 1'b0;
  logic         clr_b = 1'b0;
  logic         go_a = 1'b0;
  logic         go_b = 1'b0;
  logic         en_a = 1'b0;
  logic         en_b = 1'b0;
  cfg_t         cfg;
  req_t         cmd_a;
  req_t         cmd_b;
  req_t         req_a;
  req_t         req_b;
  logic         ce_a;
  logic         ce_b;
  logic         cfg_err;
  logic [71:0]  dout_a;
  logic [71:0]  dout_b;
  logic [143:0] got;
  logic [143:0] d;
  int           failures = 0;
  int           total_checks = 0;
  row_t         rows [8];

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  bigram_user user_a (.core_clk, .rst_n, .go(go_a), .en(en_a),
    .cmd(cmd_a), .ce(ce_a), .req(req_a));
  bigram_user user_b (.core_clk, .rst_n, .go(go_b), .en(en_b),
    .cmd(cmd_b), .ce(ce_b), .req(req_b));
  bigram dut_u (.core_clk, .rst_n, .clk_en, .cfg, .ce_a, .clr_a,
    .req_a, .ce_b, .clr_b, .req_b, .dout_a, .dout_b, .cfg_err);

  // advance n edges, landing just after the last one
  task automatic step(int n = 1);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic chk(logic [143:0] g, logic [143:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic idle();
    go_a = 1'b0;
    en_a = 1'b0;
    go_b = 1'b0;
    en_b = 1'b0;
  endtask

  // one write; the 144-bit width also loads port b's half
  task automatic wr(logic [15:0] a, logic [143:0] v, logic [15:0] b);
    cmd_a = '{1'b1, a, v[71:0], b[7:0]};
    cmd_b = '{1'b1, a, v[143:72], b[15:8]};
    go_a = 1'b1;
    en_a = 1'b1;
    go_b = (cfg.wc_a == W144);
    en_b = go_b;
    step();
  endtask

  // read held long enough for either output stage setting
  task automatic rd(logic [15:0] a);
    logic sp;
    sp = (cfg.mode == MODE_SP);
    cmd_a.we = 1'b0;
    cmd_a.addr = a;
    cmd_b.we = 1'b0;
    cmd_b.addr = a;
    go_a = sp;
    en_a = sp;
    go_b = !sp;
    en_b = !sp;
    step(6);
    if (cfg.wc_b == W144)
      got = {dout_b, dout_a};
    else
      got = sp ? {72'h0, dout_a} : {72'h0, dout_b};
  endtask

  // expected word: masked lanes keep the old value, upper bits zero
  function automatic logic [143:0] mrg(width_t w, logic [143:0] o,
    logic [143:0] n, logic [15:0] b);
    mrg = '0;
    for (int i = 0; i < (1 << w); i++)
      mrg[9*i+:9] = b[i] ? n[9*i+:9] : o[9*i+:9];
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog against a stalled run
  initial
  begin
    #200000;
    failures++;
    test_done();
  end

  initial
  begin
    cfg = '{MODE_TDP, W9, W9, 1'b0, 1'b0};
    rows = '{
      '{MODE_TDP, W9, 1'b0, 16'h0005, 9'h1a5, 16'h0001},
      '{MODE_TDP, W18, 1'b1, 16'h7fff, 9'h0c3, 16'h0002},
      '{MODE_TDP, W36, 1'b0, 16'h3ffe, 9'h13c, 16'h0005},
      '{MODE_TDP, W72, 1'b1, 16'h0fff, 9'h05a, 16'h00a5},
      '{MODE_SDP, W72, 1'b0, 16'h0123, 9'h111, 16'h0000},
      '{MODE_SDP, W144, 1'b1, 16'h0fff, 9'h0f0, 16'h8001},
      '{MODE_SP, W36, 1'b0, 16'h0040, 9'h1e1, 16'h000f},
      '{MODE_FIFO, W18, 1'b1, 16'h0000, 9'h0aa, 16'h0003}};
    step(4);
    chk({dout_b, dout_a}, '0);
    chk({143'h0, cfg_err}, '0);
    rst_n = 1'b1;
    step();
    chk({dout_b, dout_a}, '0);
    $display("reset test done");
    foreach (rows[k])
    begin
      cfg = '{rows[k].m, rows[k].w, rows[k].w, rows[k].o, rows[k].o};
      d = {8{rows[k].p, ~rows[k].p}};
      wr(rows[k].a, ~d, 16'hffff);
      wr(rows[k].a, d, rows[k].b);
      rd(rows[k].a);
      chk(got, mrg(rows[k].w, ~d, d, rows[k].b));
      chk({143'h0, cfg_err}, '0);
      idle();
      $display("row %0d done", k);
    end
    // mixed widths: 72-bit write, 9-bit read of lane 11, the word's lane 3
    cfg = '{MODE_TDP, W72, W9, 1'b0, 1'b0};
    wr(16'h0001, d, 16'hffff);
    rd(16'h000b);
    chk(got, {135'h0, d[35:27]});
    $display("mixed width test done");
    // write offered with the port enable low is not taken
    cmd_a = '{1'b1, 16'h0001, ~d[71:0], 8'hff};
    go_a = 1'b1;
    en_a = 1'b0;
    step(3);
    rd(16'h000b);
    chk(got, {135'h0, d[35:27]});
    // global enable low freezes the read path
    cmd_b.addr = 16'h0000;
    clk_en = 1'b0;
    step(3);
    chk({72'h0, dout_b}, {135'h0, d[35:27]});
    clk_en = 1'b1;
    $display("enable test done");
    clr_a = 1'b1;
    clr_b = 1'b1;
    step(2);
    chk({dout_b, dout_a}, '0);
    clr_a = 1'b0;
    clr_b = 1'b0;
    idle();
    $display("clear test done");
    cfg = '{MODE_TDP, W144, W144, 1'b0, 1'b0};
    step(2);
    chk({143'h0, cfg_err}, 144'h1);
    cfg.mode = MODE_SDP;
    cfg.wc_b = W72;
    step(2);
    chk({143'h0, cfg_err}, 144'h1);
    $display("config test done");
    // reset in mid-run drops the status at once; it returns after release
    rst_n = 1'b0;
    step();
    chk({143'h0, cfg_err}, '0);
    rst_n = 1'b1;
    step();
    chk({143'h0, cfg_err}, 144'h1);
    $display("mid reset test done");
    test_done();
  end
endmodule // bigram_tb
